/* File: logic/irq_consts.vh */
// constants shared by the interrupt enable and flag logic
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

// ***************************************************************
// register offsets on the plain register port
// ***************************************************************
`define ADDR_W                3
`define OFS_INTERRUPT_CONTROL 3'h0
`define OFS_PERIPH_ENABLE     3'h1
`define OFS_PERIPH_FLAG       3'h2
`define OFS_PORT_CHANGE_MASK  3'h3
`define OFS_EDGE_CONFIG       3'h4

// ***************************************************************
// interrupt control register fields
// ***************************************************************
`define CTL_GLOBAL_EN     7
`define CTL_PERIPH_EN     6
`define CTL_TIMER0_EN     5
`define CTL_EXT_EN        4
`define CTL_PORT_EN       3
`define CTL_TIMER0_FLAG   2
`define CTL_EXT_FLAG      1
`define CTL_PORT_FLAG     0

// ***************************************************************
// peripheral enable and flag register fields (same layout)
// ***************************************************************
`define PER_ADC           6
`define PER_CAPCMP        5
`define PER_CMP_TWO       4
`define PER_CMP_ONE       3
`define PER_TIMER2        1
`define PER_TIMER1        0
`define PER_IMPL_MASK     8'h7B

// ***************************************************************
// edge configuration and port change mask fields
// ***************************************************************
`define EDGE_SELECT_BIT   6
`define EDGE_IMPL_MASK    8'h40
`define PORT_PINS         6
`define PORT_IMPL_MASK    8'h3F

// ***************************************************************
// reset values
// ***************************************************************
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_PERIPH_ENABLE     8'h00
`define RST_PERIPH_FLAG       8'h00
`define RST_PORT_CHANGE_MASK  8'h00
`define RST_EDGE_CONFIG       8'h40

`endif

/* File: logic/sticky_flags.v */
// bank of event flags that hardware sets and software writes
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             srst,
    input  wire [WIDTH-1:0] set_event,
    input  wire             write_en,
    input  wire [WIDTH-1:0] write_val,
    input  wire [WIDTH-1:0] impl_mask,
    output wire [WIDTH-1:0] flags
);

    reg [WIDTH-1:0] flag_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // a set in the same cycle as a software clear wins, so no event is lost
            always @(posedge clock) begin
                if (srst) begin
                    flag_r[i] <= 1'b0;
                end else if (!impl_mask[i]) begin
                    flag_r[i] <= 1'b0;
                end else if (set_event[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (write_en) begin
                    flag_r[i] <= write_val[i];
                end
            end
        end
    endgenerate

    assign flags = flag_r;

endmodule

`default_nettype wire

/* File: logic/change_detect.v */
// per-bit change detector with an enable mask
`timescale 1ns/1ns
`default_nettype none

module change_detect #(
    parameter WIDTH = 6
) (
    input  wire             clock,
    input  wire             srst,
    input  wire [WIDTH-1:0] level_in,
    input  wire [WIDTH-1:0] enable_mask,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall,
    output wire             any_change
);

    reg  [WIDTH-1:0] prev_r;
    reg              armed_r;
    wire [WIDTH-1:0] diff;

    // the previous sample is not trusted until one cycle after reset,
    // so leaving reset never raises a false change
    always @(posedge clock) begin
        if (srst) begin
            prev_r  <= {WIDTH{1'b0}};
            armed_r <= 1'b0;
        end else begin
            prev_r  <= level_in;
            armed_r <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign diff[i] = armed_r & (level_in[i] ^ prev_r[i]);
            assign rise[i] = diff[i] & level_in[i];
            assign fall[i] = diff[i] & ~level_in[i];
        end
    endgenerate

    assign any_change = |(diff & enable_mask);

endmodule

`default_nettype wire

/* File: logic/interrupt_enable_flag_logic.v */
// interrupt enable, flag latching and request gating for the core
//
// Contract
// R1: global enable bit 7 gates every request
// R2: peripheral enable bit 6 gates peripheral sources
// R3: peripheral sources need peripheral enable set
// R4: bit 5 enables timer0 overflow interrupt
// R5: bit 4 enables external pin interrupt
// R6: bit 3 plus pin mask enable port change
// R7: timer0 flag bit 2 sticky on rollover
// R8: timer0 counter untouched by reset here
// R9: external flag bit 1 sticky on pin event
// R10: port change flag bit 0 on pin change
// R11: flags set regardless of any enable (port change flag here needs its pin mask bit set)
// R12: software clears flags before enabling sources
// R13: peripheral enable bits 7, 2 read zero
// R14: peripheral bit 6 enables adc done interrupt
// R15: peripheral bit 5 enables capture/compare interrupt
// R16: bits 4, 3 enable comparators two, one
// R17: peripheral bit 1 enables timer2 match interrupt
// R18: peripheral bit 0 enables timer1 overflow interrupt
// R19: edge select picks rising or falling edge
// R20: peripheral flags held in separate flag register
// R21: request is global and of enabled flags
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "irq_consts.vh"

module interrupt_enable_flag_logic (
    input  wire                 clock,
    input  wire                 srst,
    // register port
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata,
    // event sources
    input  wire                 timer0_rollover,
    input  wire                 ext_irq_pin,
    input  wire [`PORT_PINS-1:0] port_a_pins,
    input  wire                 adc_done,
    input  wire                 capture_compare_event,
    input  wire                 comparator_two_change,
    input  wire                 comparator_one_change,
    input  wire                 timer2_match,
    input  wire                 timer1_overflow,
    // request to the core
    output reg                  irq_request
);

    // ***************************************************************
    // address decode
    // ***************************************************************
    reg wr_ctrl;
    reg wr_pen;
    reg wr_pflag;
    reg wr_pmask;
    reg wr_edge;

    always @* begin
        wr_ctrl  = 1'b0;
        wr_pen   = 1'b0;
        wr_pflag = 1'b0;
        wr_pmask = 1'b0;
        wr_edge  = 1'b0;
        if (reg_wr) begin
            if (reg_addr == `OFS_INTERRUPT_CONTROL) begin
                wr_ctrl = 1'b1;
            end else if (reg_addr == `OFS_PERIPH_ENABLE) begin
                wr_pen = 1'b1;
            end else if (reg_addr == `OFS_PERIPH_FLAG) begin
                wr_pflag = 1'b1;
            end else if (reg_addr == `OFS_PORT_CHANGE_MASK) begin
                wr_pmask = 1'b1;
            end else if (reg_addr == `OFS_EDGE_CONFIG) begin
                wr_edge = 1'b1;
            end
        end
    end

    // ***************************************************************
    // enable bits of the interrupt control register
    // ***************************************************************
    // reset images kept at full register width so single fields can be picked out
    localparam [7:0] ctl_reset_val  = `RST_INTERRUPT_CONTROL;
    localparam [7:0] edge_reset_val = `RST_EDGE_CONFIG;
    localparam [7:0] mask_reset_val = `RST_PORT_CHANGE_MASK & `PORT_IMPL_MASK;

    reg global_irq_enable_r;
    reg peripheral_group_irq_enable_r;
    reg timer0_overflow_irq_enable_r;
    reg ext_pin_irq_enable_r;
    reg port_change_irq_enable_r;

    always @(posedge clock) begin
        if (srst) begin
            global_irq_enable_r           <= ctl_reset_val[`CTL_GLOBAL_EN];
            peripheral_group_irq_enable_r <= 1'b0;
            timer0_overflow_irq_enable_r  <= 1'b0;
            ext_pin_irq_enable_r          <= 1'b0;
            port_change_irq_enable_r      <= 1'b0;
        end else if (wr_ctrl) begin
            global_irq_enable_r           <= reg_wdata[`CTL_GLOBAL_EN];
            peripheral_group_irq_enable_r <= reg_wdata[`CTL_PERIPH_EN];
            timer0_overflow_irq_enable_r  <= reg_wdata[`CTL_TIMER0_EN];
            ext_pin_irq_enable_r          <= reg_wdata[`CTL_EXT_EN];
            port_change_irq_enable_r      <= reg_wdata[`CTL_PORT_EN];
        end
    end

    // ***************************************************************
    // peripheral enable, port change mask and edge configuration
    // ***************************************************************
    reg [7:0]            peripheral_enable_r;
    reg [`PORT_PINS-1:0] port_change_mask_r;
    reg                  ext_edge_select_r;

    always @(posedge clock) begin
        if (srst) begin
            peripheral_enable_r <= `RST_PERIPH_ENABLE;
            port_change_mask_r  <= mask_reset_val[`PORT_PINS-1:0];
            ext_edge_select_r   <= edge_reset_val[`EDGE_SELECT_BIT];
        end else begin
            if (wr_pen) begin
                // unimplemented bits are never stored, so they read zero
                peripheral_enable_r <= reg_wdata & `PER_IMPL_MASK; // see R13
            end
            if (wr_pmask) begin
                port_change_mask_r <= reg_wdata[`PORT_PINS-1:0];
            end
            if (wr_edge) begin
                ext_edge_select_r <= reg_wdata[`EDGE_SELECT_BIT];
            end
        end
    end

    // ***************************************************************
    // event detection
    // ***************************************************************
    wire [`PORT_PINS-1:0] port_rise;
    wire [`PORT_PINS-1:0] port_fall;
    wire                  port_changed;
    wire                  ext_rise;
    wire                  ext_fall;
    wire                  ext_event;

    // only pins enabled in the mask can raise the port change event
    change_detect #(
        .WIDTH      (`PORT_PINS)
    ) u_port_change (
        .clock      (clock),
        .srst       (srst),
        .level_in   (port_a_pins),
        .enable_mask(port_change_mask_r),
        .rise       (port_rise),
        .fall       (port_fall),
        .any_change (port_changed)
    ); // see R6 see R10

    change_detect #(
        .WIDTH      (1)
    ) u_ext_edge (
        .clock      (clock),
        .srst       (srst),
        .level_in   (ext_irq_pin),
        .enable_mask(1'b1),
        .rise       (ext_rise),
        .fall       (ext_fall),
        .any_change ()
    );

    // the edge select is applied on detection; changing it never fakes an event
    assign ext_event = ext_edge_select_r ? ext_rise : ext_fall; // see R19

    // ***************************************************************
    // core flags: timer0, external pin, port change
    // ***************************************************************
    wire [2:0] core_set;
    wire [2:0] core_flags;

    // flags latch whatever the control and peripheral enables say; only the pin mask gates before a flag, for port change
    assign core_set = {timer0_rollover, ext_event, port_changed}; // see R11

    // the timer0 counter lives outside and is not reset from here;
    // only its rollover pulse is seen by this block
    sticky_flags #(
        .WIDTH     (3)
    ) u_core_flags (
        .clock     (clock),
        .srst      (srst),
        .set_event (core_set),
        .write_en  (wr_ctrl),
        .write_val (reg_wdata[`CTL_TIMER0_FLAG:`CTL_PORT_FLAG]),
        .impl_mask (3'h7),
        .flags     (core_flags)
    ); // see R7 see R8 see R9 see R10

    wire timer0_overflow_flag = core_flags[2];
    wire ext_pin_irq_flag     = core_flags[1];
    wire port_change_flag     = core_flags[0];

    // ***************************************************************
    // peripheral flags
    // ***************************************************************
    wire [7:0] periph_set;
    wire [7:0] peripheral_flags;

    assign periph_set[7]            = 1'b0;
    assign periph_set[`PER_ADC]     = adc_done;
    assign periph_set[`PER_CAPCMP]  = capture_compare_event;
    assign periph_set[`PER_CMP_TWO] = comparator_two_change;
    assign periph_set[`PER_CMP_ONE] = comparator_one_change;
    assign periph_set[2]            = 1'b0;
    assign periph_set[`PER_TIMER2]  = timer2_match;
    assign periph_set[`PER_TIMER1]  = timer1_overflow;

    sticky_flags #(
        .WIDTH     (8)
    ) u_periph_flags (
        .clock     (clock),
        .srst      (srst),
        .set_event (periph_set),
        .write_en  (wr_pflag),
        .write_val (reg_wdata),
        .impl_mask (`PER_IMPL_MASK),
        .flags     (peripheral_flags)
    ); // see R20 see R11

    // ***************************************************************
    // request gating
    // ***************************************************************
    wire [7:0] periph_pending;
    wire       periph_any;
    wire       core_any;
    wire       irq_nxt;

    // each peripheral flag needs its own enable bit
    assign periph_pending = peripheral_flags & peripheral_enable_r; // see R14 see R15 see R16 see R17 see R18

    // the group enable blocks all peripheral sources at once
    assign periph_any = peripheral_group_irq_enable_r & (|periph_pending); // see R2 see R3

    assign core_any = (timer0_overflow_irq_enable_r & timer0_overflow_flag)   // see R4
                    | (ext_pin_irq_enable_r & ext_pin_irq_flag)               // see R5
                    | (port_change_irq_enable_r & port_change_flag);          // see R6

    // a stale flag raises the request as soon as its enable is written;
    // software is expected to clear flags first
    assign irq_nxt = global_irq_enable_r & (core_any | periph_any); // see R1 see R21 see R12

    always @(posedge clock) begin
        if (srst) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= irq_nxt;
        end
    end

    // ***************************************************************
    // read back
    // ***************************************************************
    reg [7:0] rd_val;

    always @* begin
        rd_val = 8'h00;
        if (reg_addr == `OFS_INTERRUPT_CONTROL) begin
            rd_val = {global_irq_enable_r,
                      peripheral_group_irq_enable_r,
                      timer0_overflow_irq_enable_r,
                      ext_pin_irq_enable_r,
                      port_change_irq_enable_r,
                      core_flags};
        end else if (reg_addr == `OFS_PERIPH_ENABLE) begin
            rd_val = peripheral_enable_r & `PER_IMPL_MASK; // see R13
        end else if (reg_addr == `OFS_PERIPH_FLAG) begin
            rd_val = peripheral_flags & `PER_IMPL_MASK;
        end else if (reg_addr == `OFS_PORT_CHANGE_MASK) begin
            rd_val = {2'h0, port_change_mask_r};
        end else if (reg_addr == `OFS_EDGE_CONFIG) begin
            rd_val = {1'b0, ext_edge_select_r, 6'h00};
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_val;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

/* File: tb/irq_checker.sv */
// concurrent checks on the register port and core request of the flag logic
`timescale 1ns/1ns
`default_nettype none
`include "irq_consts.vh"
module irq_checker (
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic [`ADDR_W-1:0]    reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  timer0_rollover,
    input wire logic                  ext_irq_pin,
    input wire logic [`PORT_PINS-1:0] port_a_pins,
    input wire logic                  adc_done,
    input wire logic                  capture_compare_event,
    input wire logic                  comparator_two_change,
    input wire logic                  comparator_one_change,
    input wire logic                  timer2_match,
    input wire logic                  timer1_overflow,
    input wire logic                  irq_request
);
    logic [7:3] ctl_en_r;
    logic [7:0] pen_r;
    logic       edge_r;
    logic       wr_ctl;
    logic       wr_pen;
    logic       wr_edge;
    logic       core_any;
    logic       per_any;
    assign wr_ctl = reg_wr && (reg_addr == 3'h0);
    assign wr_pen = reg_wr && (reg_addr == 3'h1);
    assign wr_edge = reg_wr && (reg_addr == 3'h4);
    assign core_any = |ctl_en_r[5:3];
    assign per_any = ctl_en_r[6] && (|pen_r);
    // ***************************************************************
    // shadow of software-only bits; flags move with events, so not kept
    // ***************************************************************
    always @(posedge clock) begin
        if (srst) begin
            ctl_en_r <= 5'h00;
            pen_r <= 8'h00;
            edge_r <= 1'b1;
        end else begin
            if (wr_ctl) ctl_en_r <= reg_wdata[7:3];
            if (wr_pen) pen_r <= reg_wdata & 8'h7B;
            if (wr_edge) edge_r <= reg_wdata[6];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    chk_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data outside the answer cycle");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_pen_unimpl: assert property (reg_rd && reg_addr == 3'h1 |=> !reg_rdata[7] && !reg_rdata[2])
        else $error("unimplemented enable bits read set");
    chk_global_gate: assert property (!$past(ctl_en_r[7]) |-> !irq_request)
        else $error("request while global enable clear");
    chk_needs_enable: assert property (irq_request |-> $past(core_any) || $past(per_any))
        else $error("request with no source enabled");
    chk_timer0_req: assert property (timer0_rollover && ctl_en_r[7] && ctl_en_r[5] && !wr_ctl
        |-> ##2 irq_request) else $error("rollover gave no request");
    chk_ext_edge: assert property (!$past(srst) && ext_irq_pin != $past(ext_irq_pin)
        && ext_irq_pin == edge_r && ctl_en_r[7] && ctl_en_r[4] && !wr_ctl && !wr_edge
        |-> ##2 irq_request) else $error("selected pin edge gave no request");
    chk_periph_req: assert property (timer1_overflow && ctl_en_r[7] && ctl_en_r[6] && pen_r[0]
        && !wr_ctl && !wr_pen |-> ##2 irq_request) else $error("peripheral event gave no request");
    cover property (timer0_rollover && ctl_en_r[5]);
    cover property ($rose(irq_request));
    cover property (reg_rd && reg_addr > 3'h4);
endmodule
bind interrupt_enable_flag_logic irq_checker i_chk (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_rollover(timer0_rollover),
    .ext_irq_pin(ext_irq_pin), .port_a_pins(port_a_pins), .adc_done(adc_done),
    .capture_compare_event(capture_compare_event), .comparator_two_change(comparator_two_change),
    .comparator_one_change(comparator_one_change), .timer2_match(timer2_match),
    .timer1_overflow(timer1_overflow), .irq_request(irq_request)
);
`default_nettype wire

/* File: tb/event_source_model.sv */
// behavioural peripheral event sources and port pin levels
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
    input  wire logic       clock,
    output wire logic       timer0_rollover,
    output wire logic       ext_irq_pin,
    output wire logic [5:0] port_a_pins,
    output wire logic       adc_done,
    output wire logic       capture_compare_event,
    output wire logic       comparator_two_change,
    output wire logic       comparator_one_change,
    output wire logic       timer2_match,
    output wire logic       timer1_overflow
);
    logic [6:0] ev_r = 7'h00;
    logic [6:0] pin_r = 7'h00;
    // bit order follows the peripheral flag layout, timer0 in the unused bit 2
    assign {adc_done, capture_compare_event, comparator_two_change, comparator_one_change,
            timer0_rollover, timer2_match, timer1_overflow} = ev_r;
    assign {ext_irq_pin, port_a_pins} = pin_r;
    task automatic pulse(input logic [6:0] sel);
        @(posedge clock);
        ev_r <= sel;
        @(posedge clock);
        ev_r <= 7'h00;
    endtask
    // returns at the edge that sees the new level
    task automatic set_pins(input logic [6:0] lv);
        @(posedge clock);
        pin_r <= lv;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_interrupt_enable_flag_logic.sv */
// self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_enable_flag_logic;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    wire        irq_request, t0, ext, adc, ccp, c2, c1, t2, t1;
    wire  [5:0] pins;
    int         n_errors = 0;
    int         n_checks = 0;
    int         i;
    logic [7:0] m_ctl, m_pen, m_pfl;
    logic [7:0] rv;
    always #4 clock = ~clock;
    interrupt_enable_flag_logic i_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer0_rollover(t0), .ext_irq_pin(ext), .port_a_pins(pins), .adc_done(adc),
        .capture_compare_event(ccp), .comparator_two_change(c2), .comparator_one_change(c1),
        .timer2_match(t2), .timer1_overflow(t1), .irq_request(irq_request));
    event_source_model i_src (.clock(clock), .timer0_rollover(t0), .ext_irq_pin(ext),
        .port_a_pins(pins), .adc_done(adc), .capture_compare_event(ccp),
        .comparator_two_change(c2), .comparator_one_change(c1), .timer2_match(t2),
        .timer1_overflow(t1));
    // ***************************************************************
    // bus tasks and model
    // ***************************************************************
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask
    function automatic logic [7:0] impl(input int a);
        return (a == 0) ? 8'hFF : (a == 1 || a == 2) ? 8'h7B : (a == 3) ? 8'h3F
             : (a == 4) ? 8'h40 : 8'h00;
    endfunction
    function automatic logic [7:0] model_irq();
        return {7'h00, m_ctl[7] && ((m_ctl[5] && m_ctl[2]) || (m_ctl[4] && m_ctl[1])
            || (m_ctl[3] && m_ctl[0]) || (m_ctl[6] && (|(m_pen & m_pfl))))};
    endfunction
    task automatic gate(input logic [7:0] c, input logic [7:0] p, input logic [7:0] f);
        m_ctl = c;
        m_pen = p & 8'h7B;
        m_pfl = f & 8'h7B;
        wr(3'h1, p);
        wr(3'h2, f);
        wr(3'h0, c);
        repeat (2) @(posedge clock);
        #1;
        check("irq_request", model_irq(), {7'h00, irq_request});
    endtask
    task automatic pin_step(input logic [6:0] lv, input logic [7:0] exp);
        i_src.set_pins(lv);
        rd_chk(3'h0, exp, "pin flags");
        wr(3'h0, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        void'($urandom(32'hDB5B59CA));
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (i = 0; i < 8; i++) rd_chk(3'(i), (i == 4) ? 8'h40 : 8'h00, "reset value");
        $display("test reset values done");
        for (i = 0; i < 8; i++) begin
            rv = 8'($urandom);
            wr(3'(i), rv);
            rd_chk(3'(i), rv & impl(i), "readback");
        end
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h40);
        $display("test readback done");
        for (i = 0; i < 8; i++) begin
            gate(8'hC0, 8'h01 << i, 8'h01 << i);
            gate(8'h80, 8'h01 << i, 8'h01 << i);
            gate(8'hC0, 8'h01 << i, ~(8'h01 << i));
            gate(8'h80 | (8'h09 << (i % 3)), 8'h00, 8'h00);
            gate(8'h7F, 8'hFF, 8'hFF);
        end
        for (i = 0; i < 30; i++) gate(8'($urandom), 8'($urandom), 8'($urandom));
        gate(8'h00, 8'h00, 8'h00);
        $display("test gating done");
        i_src.pulse(7'h7F);
        rd_chk(3'h0, 8'h04, "core flags");
        rd_chk(3'h2, 8'h7B, "peripheral flags");
        check("quiet irq", 8'h00, {7'h00, irq_request});
        wr(3'h2, 8'h00);
        fork
            i_src.pulse(7'h04);
            wr(3'h0, 8'h00);
        join
        rd_chk(3'h0, 8'h04, "set beats clear");
        wr(3'h0, 8'h00);
        pin_step(7'h40, 8'h02);
        pin_step(7'h00, 8'h00);
        wr(3'h4, 8'h00);
        pin_step(7'h40, 8'h00);
        pin_step(7'h00, 8'h02);
        wr(3'h3, 8'h05);
        pin_step(7'h02, 8'h00);
        pin_step(7'h06, 8'h01);
        pin_step(7'h04, 8'h00);
        pin_step(7'h00, 8'h01);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h40);
        $display("test events done");
        wr(3'h1, 8'h01);
        wr(3'h0, 8'hF0);
        for (i = 0; i < 3; i++) begin
            if (i == 1) i_src.set_pins(7'h40);
            else i_src.pulse((i == 0) ? 7'h04 : 7'h01);
            @(posedge clock);
            #1;
            check("live irq", 8'h01, {7'h00, irq_request});
            wr(3'h2, 8'h00);
            wr(3'h0, 8'hF0);
            repeat (2) @(posedge clock);
            #1;
            check("cleared irq", 8'h00, {7'h00, irq_request});
        end
        i_src.set_pins(7'h00);
        $display("test live requests done");
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd_chk(3'h0, 8'h00, "control after reset");
        rd_chk(3'h1, 8'h00, "enable after reset");
        rd_chk(3'h4, 8'h40, "edge after reset");
        check("irq after reset", 8'h00, {7'h00, irq_request});
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
